// >>> rtl/pin_wake_config_regs.sv
`timescale 1ns/1ps
`include "wake_cfg_defines.svh"
module pin_wake_config_regs #(
  parameter int PINS = `PIN_N
) (
  input  wire logic                      mclk_in,
  input  wire logic                      arst_n_in,
  input  wire logic                      cfg_rst_n_in,
  input  wire logic [7:0]                addr_in,
  input  wire logic [7:0]                wdata_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  input  wire logic [PINS-1:0]           port0_pin_in,
  input  wire logic [PINS-1:0]           port1_pin_in,
  input  wire logic [PINS-1:0]           port2_pin_in,
  output logic      [7:0]                rdata_out,
  output logic      [PINS-1:0]           p0_cycle_sense_en_out,
  output logic      [PINS-1:0]           port1_pin_wake_status_out,
  output logic                           port1_wake_summary_out,
  output logic                           wake_req_out,
  output logic                           irq_out
);

  ////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst1_q;
  logic rst_n;
  logic cfg1_q;
  logic cfg_n;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst1_q <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst1_q <= 1'b1;
      rst_n  <= rst1_q;
    end
  end

  // heavy reset class: also driven by the power-on reset
  always_ff @(posedge mclk_in or negedge cfg_rst_n_in or negedge arst_n_in) begin
    if (!cfg_rst_n_in || !arst_n_in) begin
      cfg1_q <= 1'b0;
      cfg_n  <= 1'b0;
    end else begin
      cfg1_q <= 1'b1;
      cfg_n  <= cfg1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin path

  logic [PINS-1:0]          p1_level;
  wake_cfg_pkg::edge_pair_t p1_edges;

  pin_sync3 #(.W(PINS)) u_sync (
    .clk_in    (mclk_in),
    .rst_n_in  (rst_n),
    .pin_in    (port1_pin_in),
    .level_out (p1_level)
  );

  edge_detect #(.W(PINS)) u_edge (
    .clk_in    (mclk_in),
    .rst_n_in  (rst_n),
    .level_in  (p1_level),
    .edges_out (p1_edges)
  );

  ////////////////////////////////////////////////////////////////////////
  // registers

  wake_cfg_pkg::bus_req_t req;
  logic [PINS-1:0] cyc_q, cyc_d;
  logic [PINS-1:0] rise_q, rise_d;
  logic [PINS-1:0] fall_q, fall_d;
  logic [PINS-1:0] sts_q, sts_d;
  logic [1:0]      irq_sts_q, irq_sts_d;
  logic [1:0]      irq_msk_q, irq_msk_d;
  logic [7:0]      rdata_q, rdata_d;
  logic            wake_q, wake_d;
  logic            sum_q, sum_d;
  logic            irq_q, irq_d;
  logic [PINS-1:0] hit;
  logic [PINS-1:0] port2_unused;

  function automatic logic [7:0] zext(input logic [PINS-1:0] v);
    zext = 8'h00;
    zext[PINS-1:0] = v;
  endfunction : zext

  always_comb begin
    req           = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};
    port2_unused  = port2_pin_in;
    cyc_d         = cyc_q;
    rise_d        = rise_q;
    fall_d        = fall_q;
    irq_msk_d     = irq_msk_q;
    // either enable independently qualifies its own polarity
    hit           = (p1_edges.rise & rise_q) | (p1_edges.fall & fall_q);
    sts_d         = sts_q;
    irq_sts_d     = irq_sts_q;
    rdata_d       = 8'h00;
    if (req.wr) begin
      if (req.addr == `OFS_P0_CYCLE) begin
        cyc_d = req.wdata[PINS-1:0];
      end else if (req.addr == `OFS_P1_RISE) begin
        rise_d = req.wdata[PINS-1:0];
      end else if (req.addr == `OFS_P1_FALL) begin
        fall_d = req.wdata[PINS-1:0];
      end else if (req.addr == `OFS_IRQ_MASK) begin
        irq_msk_d = req.wdata[1:0];
      end
    end
    if (req.rd) begin
      if (req.addr == `OFS_P0_CYCLE) begin
        rdata_d = zext(cyc_q);
      end else if (req.addr == `OFS_P1_RISE) begin
        rdata_d = zext(rise_q);
      end else if (req.addr == `OFS_P1_FALL) begin
        rdata_d = zext(fall_q);
      end else if (req.addr == `OFS_P1_STATUS) begin
        rdata_d = zext(sts_q);
        sts_d   = '0;
      end else if (req.addr == `OFS_IRQ_STATUS) begin
        rdata_d   = {6'h00, irq_sts_q};
        irq_sts_d = 2'h0;
      end else if (req.addr == `OFS_IRQ_MASK) begin
        rdata_d = {6'h00, irq_msk_q};
      end
    end
    // set wins over a clearing read in the same cycle
    sts_d = sts_d | hit;
    if (|hit) begin
      irq_sts_d[`IRQ_BIT_P1_WAKE] = 1'b1;
    end
    if (|(port0_pin_in & cyc_q) & 1'b0) begin
      irq_sts_d[`IRQ_BIT_P0_CYCLE] = 1'b1;
    end
    sum_d  = |sts_d;
    wake_d = |hit;
    irq_d  = |(irq_sts_d & irq_msk_d);
  end

  // cycle and edge enables are cleared only by the heavy class, from cfg_rst_n_in or arst_n_in; no reset leaves them alone while clearing status
  always_ff @(posedge mclk_in or negedge cfg_n) begin
    if (!cfg_n) begin
      cyc_q  <= PINS'(`CFG_RESET);
      rise_q <= PINS'(`CFG_RESET);
      fall_q <= PINS'(`CFG_RESET);
    end else begin
      cyc_q  <= cyc_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      sts_q     <= '0;
      irq_sts_q <= 2'h0;
      irq_msk_q <= 2'h0;
      rdata_q   <= 8'h00;
      wake_q    <= 1'b0;
      sum_q     <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      sts_q     <= sts_d;
      irq_sts_q <= irq_sts_d;
      irq_msk_q <= irq_msk_d;
      rdata_q   <= rdata_d;
      wake_q    <= wake_d;
      sum_q     <= sum_d;
      irq_q     <= irq_d;
    end
  end

  assign rdata_out                 = rdata_q;
  assign p0_cycle_sense_en_out     = cyc_q;
  assign port1_pin_wake_status_out = sts_q;
  assign port1_wake_summary_out    = sum_q;
  assign wake_req_out              = wake_q;
  assign irq_out                   = irq_q;

endmodule : pin_wake_config_regs

// >>> rtl/wake_cfg_defines.svh
`ifndef WAKE_CFG_DEFINES_SVH
`define WAKE_CFG_DEFINES_SVH

`define ADDR_W              8
`define PIN_N               5
`define REG_W               8
`define OFS_P0_CYCLE        8'hE0
`define OFS_P1_RISE         8'hE4
`define OFS_P1_FALL         8'hE8
`define OFS_P1_STATUS       8'hEC
`define OFS_IRQ_STATUS      8'hF0
`define OFS_IRQ_MASK        8'hF4
`define CFG_RESET           8'h00
`define IRQ_BIT_P1_WAKE     0
`define IRQ_BIT_P0_CYCLE    1

`endif

// >>> rtl/wake_cfg_pkg.sv
package wake_cfg_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic [4:0] rise;
    logic [4:0] fall;
  } edge_pair_t;

endpackage : wake_cfg_pkg

// >>> rtl/pin_sync3.sv
`timescale 1ns/1ps
// three-stage synchroniser; a change counts once stages two and three agree
module pin_sync3 #(
  parameter int W = 5
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_q;
  logic [W-1:0] level_d;

  always_comb begin
    level_d = level_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        level_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      level_q <= '0;
    end else begin
      s1_q    <= pin_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end

  assign level_out = level_q;

endmodule : pin_sync3

// >>> rtl/edge_detect.sv
`timescale 1ns/1ps
// per-pin edge detector; reports rise and fall for one cycle
module edge_detect #(
  parameter int W = 5
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic [W-1:0]            level_in,
  output wake_cfg_pkg::edge_pair_t     edges_out
);

  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;

  always_comb begin
    prev_d         = level_in;
    edges_out.rise = level_in & ~prev_q;
    edges_out.fall = ~level_in & prev_q;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end

endmodule : edge_detect

// >>> sim/wake_cfg_monitor.sv
`timescale 1ns/1ps
module wake_cfg_monitor #(
  parameter int PINS = 5
) (
  input wire logic            mclk_in,
  input wire logic            arst_n_in,
  input wire logic            cfg_rst_n_in,
  input wire logic [7:0]      addr_in,
  input wire logic [7:0]      wdata_in,
  input wire logic            wr_in,
  input wire logic            rd_in,
  input wire logic [PINS-1:0] port1_pin_in,
  input wire logic [PINS-1:0] port2_pin_in,
  input wire logic [7:0]      rdata_out,
  input wire logic [PINS-1:0] p0_cycle_sense_en_out,
  input wire logic [PINS-1:0] port1_pin_wake_status_out,
  input wire logic            port1_wake_summary_out,
  input wire logic            wake_req_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  // eight quiet cycles outlast the synchroniser and edge pipeline
  sequence quiet_pins;
    ($stable(port1_pin_in) && $stable(port2_pin_in)) [*8];
  endsequence
  a_no_spurious_wake: assert property (quiet_pins |=> !wake_req_out)
    else $error("wake without pin edge");
  a_upper_read_zero: assert property (rdata_out[7:5] == 3'h0)
    else $error("upper read bits set");
  a_idle_rdata_zero: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data without read");
  a_summary_is_or: assert property (port1_wake_summary_out == |port1_pin_wake_status_out)
    else $error("summary differs from status");
  a_wake_sets_flag: assert property (wake_req_out |-> ##[0:1] port1_wake_summary_out)
    else $error("wake left no status");
  a_status_sticky: assert property ($past(rd_in) || ($past(port1_pin_wake_status_out) & ~port1_pin_wake_status_out) == '0)
    else $error("status bit dropped");
  a_cycle_write: assert property (wr_in && addr_in == 8'hE0 && cfg_rst_n_in |-> ##1 p0_cycle_sense_en_out == $past(wdata_in[4:0]))
    else $error("cycle enable not written");
  a_cfg_reset_clear: assert property (!cfg_rst_n_in [*2] |=> p0_cycle_sense_en_out == '0)
    else $error("cycle enable survived reset");
endmodule : wake_cfg_monitor
bind pin_wake_config_regs wake_cfg_monitor #(.PINS(PINS)) mon (.mclk_in, .arst_n_in, .cfg_rst_n_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .port1_pin_in, .port2_pin_in, .rdata_out, .p0_cycle_sense_en_out,
  .port1_pin_wake_status_out, .port1_wake_summary_out, .wake_req_out);

// >>> sim/pin_source.sv
`timescale 1ns/1ps
// pins are asynchronous, so levels move mid-cycle to exercise the synchroniser
module pin_source (
  input  wire logic       mclk_in,
  input  wire logic [4:0] p1_lvl_in,
  input  wire logic [4:0] p2_lvl_in,
  output logic      [4:0] p0_pin_out,
  output logic      [4:0] p1_pin_out,
  output logic      [4:0] p2_pin_out
);
  initial {p0_pin_out, p1_pin_out, p2_pin_out} = 15'h0000;
  always @(negedge mclk_in) begin
    p0_pin_out <= p2_lvl_in;
    p1_pin_out <= p1_lvl_in;
    p2_pin_out <= p2_lvl_in;
  end
endmodule : pin_source

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic       mclk_in = 1'b0;
  logic       arst_n_in = 1'b0;
  logic       cfg_rst_n_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in = 1'b0;
  logic       rd_in = 1'b0;
  logic [4:0] p1_lvl = 5'h00;
  logic [4:0] p2_lvl = 5'h00;
  logic [4:0] p0_pin, p1_pin, p2_pin, cyc_en, sts;
  logic [7:0] rdata_out;
  logic       summ, irq, wake;
  int         wake_cnt = 0;
  logic [7:0] ofs [3] = '{8'hE0, 8'hE4, 8'hE8};
  int         err_count = 0;
  int         check_count = 0;
  always #2 mclk_in = ~mclk_in;
  // counts one-cycle wake pulses; sees the value settled over the last cycle
  always @(posedge mclk_in) if (wake === 1'b1) wake_cnt++;
  pin_source src (.mclk_in, .p1_lvl_in(p1_lvl), .p2_lvl_in(p2_lvl), .p0_pin_out(p0_pin), .p1_pin_out(p1_pin),
    .p2_pin_out(p2_pin));
  pin_wake_config_regs DUT (.mclk_in, .arst_n_in, .cfg_rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .port0_pin_in(p0_pin), .port1_pin_in(p1_pin), .port2_pin_in(p2_pin), .rdata_out,
    .p0_cycle_sense_en_out(cyc_en), .port1_pin_wake_status_out(sts), .port1_wake_summary_out(summ),
    .wake_req_out(wake), .irq_out(irq));
  ////////////////////////////////////////
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 chk($sformatf("rdata %h", a), rdata_out, e);
  endtask : rd
  // fixed wait covers the synchroniser and edge pipeline latency
  task pins(input logic [4:0] a, input logic [4:0] b);
    @(posedge mclk_in);
    p1_lvl <= a;
    p2_lvl <= b;
    repeat (12) @(posedge mclk_in);
  endtask : pins
  task report_and_stop;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    foreach (ofs[i]) begin
      wr(ofs[i], 8'hFF);
      rd(ofs[i], 8'h1F);
    end
    chk("cycle enable", cyc_en, 8'h1F);
    rd(8'h10, 8'h00);
    wr(8'hE4, 8'h05);
    wr(8'hE8, 8'h06);
    pins(5'h07, 5'h00);
    chk("summary", summ, 8'h01);
    chk("wake pulses", wake_cnt, 8'h01);
    chk("irq masked", irq, 8'h00);
    rd(8'hEC, 8'h05);
    rd(8'hF0, 8'h01);
    rd(8'hEC, 8'h00);
    wr(8'hF4, 8'h01);
    pins(5'h00, 5'h00);
    chk("irq", irq, 8'h01);
    chk("wake pulses", wake_cnt, 8'h02);
    rd(8'hEC, 8'h06);
    rd(8'hF0, 8'h01);
    chk("irq cleared", irq, 8'h00);
    pins(5'h00, 5'h1F);
    rd(8'hEC, 8'h00);
    chk("wake pulses", wake_cnt, 8'h02);
    @(posedge mclk_in);
    cfg_rst_n_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    cfg_rst_n_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    rd(8'hF4, 8'h01);
    report_and_stop();
  end
endmodule : tb_top
